// *** logic/dcp_map.vh ***
// Notes on behaviour
// RULE1: mode 3: channel 1 image, label background graphics
// RULE2: mode 0: image 1 on characters, off background
// RULE3: image 1 characters win unless graphics/background conflict
// RULE4: mode 3 clears graphics into channels 1, 2
// RULE5: channel 2 mirrors channel 1 with image 2
// RULE6: priority: characters, background, graphics, image; in modes 1 and 2 the code lets graphics override characters
// RULE7: graphics overlay only stereo; background always graphics
// RULE8: mode 1 is lo only, mode 2 hi only
// RULE9: software alternates modes 1, 2 each field
// RULE10: dual enables active low, all terms false
// RULE11: image 1 to dual in modes 0, 1
// RULE12: image 2 to dual in modes 0, 2
// RULE13: mode 0 window pixels or sole image 2
// RULE14: palette only mode 0, both images, plain pixel
// RULE15: graphics to dual per half and mode
// RULE16: graphics to dual for cursor and label field; the cursor term is decoded in mode 0 only
// RULE17: mode 0 with no image gives graphics
// RULE18: mode 3 graphics act as third image
// RULE19: dual graphics clear: mode 3 background, blank 0
// RULE20: all control outputs registered on pixel clock
// RULE21: graphics halves reduced to one flag each
// RULE22: one dual source per pixel, inputs registered; mode 0 window with no image enables both image 2 and graphics
`ifndef DCP_MAP_VH
`define DCP_MAP_VH
`define DCP_ADDR_CTRL 4'h0
`define DCP_ADDR_STATUS 4'h4
`define DCP_CTRL_MODE_LO 0
`define DCP_CTRL_MODE_HI 1
`define DCP_CTRL_GFX_EN 2
`define DCP_CTRL_W 3
`define DCP_CTRL_RESET 3'h0
`define DCP_STATUS_W 10
`define DCP_RESP_OKAY 2'h0
`define DCP_RESP_SLVERR 2'h2
`define DCP_LOWER_HI 3
`define DCP_UPPER_LO 4
`define DCP_UPPER_HI 7
`endif

// *** logic/dcp_prioritizer.v ***
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dcp_map.vh"
module dcp_prioritizer (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [3:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [3:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// pixel flags
	input wire image1_active,
	input wire image2_active,
	input wire cursor0_pixel,
	input wire cursor1_pixel,
	input wire window2_pixel,
	input wire img1_label_field,
	input wire img2_label_field,
	input wire gfx_label_field,
	input wire char_pixel,
	input wire [7:0] gfx_bits,
	// channel multiplexer controls
	output reg gfx_to_ch1_en_n,
	output reg img_to_ch1_en_n,
	output reg gfx_to_ch2_en_n,
	output reg img_to_ch2_en_n,
	output reg clear_gfx_to_images_n,
	// dual channel multiplexer controls
	output reg img1_to_dual_en_n,
	output reg img2_to_dual_en_n,
	output reg dual_palette_en_n,
	output reg gfx_to_dual_en_n,
	output reg clear_gfx_to_dual_n
);

	// control register: mode bits and graphics enable
	reg [`DCP_CTRL_W-1:0] ctrl_q;
	wire mode_sel_lo;
	wire mode_sel_hi;
	wire gfx_en;
	assign mode_sel_lo = ctrl_q[`DCP_CTRL_MODE_LO];
	assign mode_sel_hi = ctrl_q[`DCP_CTRL_MODE_HI];
	assign gfx_en = ctrl_q[`DCP_CTRL_GFX_EN];

	// registered pixel inputs
	reg i1_q, i2_q, cb0_q, cb1_q, win_q, lb1_q, lb2_q, glb_q, chr_q;
	reg lower_gfx_idle_q, upper_gfx_idle_q;

	always @(posedge aclk) begin // [RULE22]
		i1_q <= image1_active;
		i2_q <= image2_active;
		cb0_q <= cursor0_pixel;
		cb1_q <= cursor1_pixel;
		win_q <= window2_pixel;
		lb1_q <= img1_label_field;
		lb2_q <= img2_label_field;
		glb_q <= gfx_label_field;
		chr_q <= char_pixel;
		lower_gfx_idle_q <= ~|gfx_bits[`DCP_LOWER_HI:0]; // [RULE21]
		upper_gfx_idle_q <= ~|gfx_bits[`DCP_UPPER_HI:`DCP_UPPER_LO]; // [RULE21]
	end

	// mode decode
	wire m0, m1, m2, m3, stereo;
	assign m0 = ~mode_sel_hi & ~mode_sel_lo;
	assign m1 = ~mode_sel_hi & mode_sel_lo; // [RULE8]
	assign m2 = mode_sel_hi & ~mode_sel_lo; // [RULE8]
	assign m3 = mode_sel_hi & mode_sel_lo;
	assign stereo = m1 | m2; // [RULE9]

	wire lo_act, up_act, curs;
	assign lo_act = ~lower_gfx_idle_q;
	assign up_act = ~upper_gfx_idle_q;
	assign curs = cb0_q | cb1_q;

	// channel selects: high picks graphics, low picks the image
	wire sc1, sc2;
	// label background first, then stereo graphics, else image
	assign sc1 = (lb1_q & ~chr_q) | (stereo & (glb_q | lo_act)); // [RULE1] [RULE2] [RULE3] [RULE6] [RULE7]
	assign sc2 = (lb2_q & ~chr_q) | (stereo & (glb_q | up_act)); // [RULE5] [RULE6] [RULE7]

	// dual channel terms; dc1, dc2 and dce high mean blocked
	wire dc1, dc2, dce, gde, cld;
	assign dc1 = mode_sel_hi | (m0 & (curs | win_q)) | (lo_act & gfx_en & ~mode_sel_hi) |
		(up_act & gfx_en & m0) | glb_q | (m0 & (~i1_q | i2_q)); // [RULE10] [RULE11]
	assign dc2 = mode_sel_lo | (m0 & curs) | (m0 & gfx_en & lo_act) |
		(gfx_en & up_act & ~mode_sel_lo) | glb_q |
		(m0 & ~win_q & ~(i2_q & ~i1_q)); // [RULE10] [RULE12] [RULE13]
	assign dce = mode_sel_hi | mode_sel_lo | curs | win_q | (gfx_en & (lo_act | up_act)) |
		~i1_q | ~i2_q | glb_q; // [RULE10] [RULE14]
	// graphics enable is true-active, inverted into the output
	assign gde = (lo_act & gfx_en & ~mode_sel_hi) | (up_act & gfx_en & ~mode_sel_lo) | // [RULE15]
		(m0 & curs) | glb_q | // [RULE16]
		(m0 & ~i1_q & ~i2_q) | // [RULE17]
		m3; // [RULE18]
	assign cld = (glb_q & ~chr_q & m3) |
		(m0 & ~curs & ~gfx_en & ~i1_q & ~i2_q); // [RULE19]

	// output realignment; reset parks everything deasserted
	always @(posedge aclk) begin // [RULE20]
		if (!aresetn) begin
			gfx_to_ch1_en_n <= 1'b1;
			img_to_ch1_en_n <= 1'b1;
			gfx_to_ch2_en_n <= 1'b1;
			img_to_ch2_en_n <= 1'b1;
			clear_gfx_to_images_n <= 1'b1;
			img1_to_dual_en_n <= 1'b1;
			img2_to_dual_en_n <= 1'b1;
			dual_palette_en_n <= 1'b1;
			gfx_to_dual_en_n <= 1'b1;
			clear_gfx_to_dual_n <= 1'b1;
		end else begin
			img_to_ch1_en_n <= sc1;
			gfx_to_ch1_en_n <= ~sc1;
			img_to_ch2_en_n <= sc2; // [RULE5]
			gfx_to_ch2_en_n <= ~sc2;
			clear_gfx_to_images_n <= ~m3; // [RULE4]
			img1_to_dual_en_n <= dc1;
			img2_to_dual_en_n <= dc2;
			dual_palette_en_n <= dce;
			gfx_to_dual_en_n <= ~gde;
			clear_gfx_to_dual_n <= ~cld;
		end
	end

	// ---- axi4-lite slave ----
	reg aw_hold_q, w_hold_q;
	reg [3:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	wire aw_take, w_take, do_write, ar_take;
	wire aw_hold_d, w_hold_d, bvalid_d, rvalid_d;
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	// commit in the cycle both halves are held, only with no response pending
	assign do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;
	assign aw_hold_d = (aw_hold_q & ~do_write) | aw_take;
	assign w_hold_d = (w_hold_q & ~do_write) | w_take;
	assign bvalid_d = (s_axi_bvalid & ~s_axi_bready) | do_write;
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign rvalid_d = (s_axi_rvalid & ~s_axi_rready) | ar_take;

	wire [`DCP_STATUS_W-1:0] status;
	assign status = {clear_gfx_to_dual_n, gfx_to_dual_en_n, dual_palette_en_n,
		img2_to_dual_en_n, img1_to_dual_en_n, clear_gfx_to_images_n,
		img_to_ch2_en_n, gfx_to_ch2_en_n, img_to_ch1_en_n, gfx_to_ch1_en_n};

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 4'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			ctrl_q <= `DCP_CTRL_RESET;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DCP_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `DCP_RESP_OKAY;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			s_axi_awready <= ~aw_hold_d;
			s_axi_wready <= ~w_hold_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_arready <= ~rvalid_d;
			s_axi_rvalid <= rvalid_d;
			if (aw_take) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				if (awaddr_q == `DCP_ADDR_CTRL) begin
					s_axi_bresp <= `DCP_RESP_OKAY;
					if (wstrb_q[0]) begin
						ctrl_q <= wdata_q[`DCP_CTRL_W-1:0];
					end
				end else if (awaddr_q == `DCP_ADDR_STATUS) begin
					// status is read-only; write is dropped quietly
					s_axi_bresp <= `DCP_RESP_OKAY;
				end else begin
					s_axi_bresp <= `DCP_RESP_SLVERR;
				end
			end
			if (ar_take) begin
				case (s_axi_araddr)
				`DCP_ADDR_CTRL: begin
					s_axi_rdata <= {29'h0, ctrl_q};
					s_axi_rresp <= `DCP_RESP_OKAY;
				end
				`DCP_ADDR_STATUS: begin
					s_axi_rdata <= {22'h0, status};
					s_axi_rresp <= `DCP_RESP_OKAY;
				end
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= `DCP_RESP_SLVERR;
				end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// *** bench/dcp_dac_mux.sv ***
`timescale 1ns/1ns
`default_nettype none
module dcp_dac_mux (
	// dual channel enables, all low active
	input wire logic img1_n,
	input wire logic img2_n,
	input wire logic pal_n,
	input wire logic gfx_n,
	input wire logic clr_n,
	// source seen at the dac: 5 blanked graphics, 7 contention
	output logic [2:0] src
);
	always_comb begin
		case ({img1_n, img2_n, pal_n, gfx_n})
			4'h7: src = 3'h1;
			4'hB: src = 3'h2;
			4'hD: src = 3'h3;
			4'hE: src = clr_n ? 3'h4 : 3'h5;
			4'hF: src = 3'h0;
			default: src = 3'h7;
		endcase
	end
endmodule
`default_nettype wire

// *** bench/dcp_prioritizer_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module dcp_prioritizer_chk (
	// clock, reset
	input wire logic aclk, aresetn,
	// pixel flags
	input wire logic image1_active, image2_active, cursor0_pixel, cursor1_pixel,
	input wire logic window2_pixel, img1_label_field, img2_label_field,
	input wire logic gfx_label_field, char_pixel,
	// controls
	input wire logic gfx_to_ch1_en_n, img_to_ch1_en_n, gfx_to_ch2_en_n, img_to_ch2_en_n,
	input wire logic clear_gfx_to_images_n, img1_to_dual_en_n, img2_to_dual_en_n,
	input wire logic dual_palette_en_n, gfx_to_dual_en_n, clear_gfx_to_dual_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [1:0] up_q;
	logic ok;
	logic m3;
	// outputs hold reset values until the pipe refills
	assign ok = up_q == 2'h3;
	assign m3 = ok && !clear_gfx_to_images_n;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			up_q <= 2'h0;
		else if (!ok)
			up_q <= up_q + 2'h1;
	end
	sequence s_glb;
		ok && gfx_label_field ##2 1'b1;
	endsequence
	sequence s_blk;
		ok && (cursor0_pixel || cursor1_pixel || window2_pixel || !image1_active
			|| !image2_active || gfx_label_field) ##2 1'b1;
	endsequence
	a_ch_compl: assert property (ok |-> gfx_to_ch1_en_n != img_to_ch1_en_n
		&& gfx_to_ch2_en_n != img_to_ch2_en_n) else $error("channel selects overlap");
	a_mode3_ch1: assert property (m3 |-> img_to_ch1_en_n ==
		($past(img1_label_field, 2) && !$past(char_pixel, 2))) else $error("ch1 mode3");
	a_mode3_ch2: assert property (m3 |-> img_to_ch2_en_n ==
		($past(img2_label_field, 2) && !$past(char_pixel, 2))) else $error("ch2 mode3");
	a_mode3_dual: assert property (m3 |-> !gfx_to_dual_en_n && img1_to_dual_en_n
		&& img2_to_dual_en_n && dual_palette_en_n) else $error("dual mode3");
	a_mode3_clr: assert property (m3 |-> clear_gfx_to_dual_n ==
		!($past(gfx_label_field, 2) && !$past(char_pixel, 2))) else $error("dual clear");
	a_pal_block: assert property (s_blk |-> dual_palette_en_n)
		else $error("palette not blocked");
	a_glb_dual: assert property (s_glb |-> !gfx_to_dual_en_n && img1_to_dual_en_n
		&& img2_to_dual_en_n) else $error("label field not graphics");
	a_one_src: assert property (ok |-> !(img1_to_dual_en_n && img2_to_dual_en_n
		&& dual_palette_en_n && gfx_to_dual_en_n)) else $error("dual has no source");
endmodule
`default_nettype wire

// *** bench/dcp_prioritizer_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module dcp_prioritizer_bench;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic s_axi_bready = 1, s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [16:0] pix = 0;
	wire [9:0] ctl;
	wire [2:0] src;
	int n_mismatch = 0, n_tests = 0, cyc = 0;
	always #10 aclk = ~aclk;
	dcp_prioritizer dcp_prioritizer_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .image1_active(pix[16]), .image2_active(pix[15]),
		.cursor0_pixel(pix[14]), .cursor1_pixel(pix[13]), .window2_pixel(pix[12]),
		.img1_label_field(pix[11]), .img2_label_field(pix[10]), .gfx_label_field(pix[9]),
		.char_pixel(pix[8]), .gfx_bits(pix[7:0]), .gfx_to_ch1_en_n(ctl[0]),
		.img_to_ch1_en_n(ctl[1]), .gfx_to_ch2_en_n(ctl[2]), .img_to_ch2_en_n(ctl[3]),
		.clear_gfx_to_images_n(ctl[4]), .img1_to_dual_en_n(ctl[5]),
		.img2_to_dual_en_n(ctl[6]), .dual_palette_en_n(ctl[7]), .gfx_to_dual_en_n(ctl[8]),
		.clear_gfx_to_dual_n(ctl[9]));
	dcp_dac_mux dcp_dac_mux_i (.img1_n(ctl[5]), .img2_n(ctl[6]), .pal_n(ctl[7]),
		.gfx_n(ctl[8]), .clr_n(ctl[9]), .src(src));
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			final_report;
		end
	end
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		bit aw = 1;
		bit w = 1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_axi_awready) begin
				aw = 0;
				s_axi_awvalid <= 0;
			end
			if (w && s_axi_wready) begin
				w = 0;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		cmp("bresp", r, s_axi_bresp);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		cmp("rdata", d, s_axi_rdata);
		cmp("rresp", r, s_axi_rresp);
	endtask
	// ctrl, pixel {i1 i2 c0 c1 w2 l1 l2 gl ch gfx}, dual source, enables {gfx2 img2 gfx1 img1}
	// image on both channels reads 4'hA, since each pair is low active
	task automatic chk(input logic [2:0] c, input logic [16:0] p, input logic [2:0] es,
		input logic [3:0] ech);
		wr(4'h0, {29'h0, c}, 2'h0);
		pix <= p;
		repeat (3) @(posedge aclk);
		#1;
		cmp("src", es, src);
		cmp("chan", {c[1:0] != 2'h3, ech}, {ctl[4], ctl[2], ctl[3], ctl[0], ctl[1]});
	endtask
	task automatic t_regs;
		rd(4'h0, 0, 2'h0);
		wr(4'h0, 7, 2'h0);
		rd(4'h0, 7, 2'h0);
		wr(4'h8, 1, 2'h2);
		rd(4'hC, 0, 2'h2);
		wr(4'h4, 0, 2'h0);
		chk(3'h0, {9'h100, 8'h00}, 3'h1, 4'hA);
		rd(4'h4, 32'h3D5, 2'h0);
		$display("test regs done");
	endtask
	task automatic t_mode0;
		chk(3'h0, {9'h140, 8'h00}, 3'h4, 4'hA);
		chk(3'h0, {9'h180, 8'h00}, 3'h3, 4'hA);
		chk(3'h0, {9'h190, 8'h00}, 3'h2, 4'hA);
		chk(3'h0, {9'h080, 8'h00}, 3'h2, 4'hA);
		chk(3'h0, {9'h000, 8'h00}, 3'h5, 4'hA);
		chk(3'h0, {9'h182, 8'h00}, 3'h4, 4'hA);
		chk(3'h0, {9'h108, 8'h00}, 3'h1, 4'h9);
		chk(3'h0, {9'h109, 8'h00}, 3'h1, 4'hA);
		chk(3'h4, {9'h180, 8'h01}, 3'h4, 4'hA);
		chk(3'h4, {9'h000, 8'h00}, 3'h4, 4'hA);
		$display("test mode0 done");
	endtask
	// modes 1 and 2 alternate as a field-rate source would drive them
	task automatic t_stereo;
		chk(3'h5, {9'h180, 8'h00}, 3'h1, 4'hA);
		chk(3'h6, {9'h180, 8'h80}, 3'h4, 4'h6);
		chk(3'h5, {9'h180, 8'h08}, 3'h4, 4'h9);
		chk(3'h6, {9'h180, 8'h01}, 3'h2, 4'h9);
		chk(3'h5, {9'h180, 8'h80}, 3'h1, 4'h6);
		chk(3'h6, {9'h182, 8'h00}, 3'h4, 4'h5);
		$display("test stereo done");
	endtask
	task automatic t_mode3;
		chk(3'h3, {9'h180, 8'h00}, 3'h4, 4'hA);
		chk(3'h3, {9'h188, 8'h00}, 3'h4, 4'h9);
		chk(3'h3, {9'h182, 8'h00}, 3'h5, 4'hA);
		$display("test mode3 done");
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		t_regs;
		t_mode0;
		t_stereo;
		t_mode3;
		final_report;
	end
endmodule
bind dcp_prioritizer dcp_prioritizer_chk dcp_prioritizer_chk_i (.*);
`default_nettype wire
